// File: hdl/tcu_capture_unit.sv
// tcu_capture_unit: capture/compare unit with apb registers
// assumes the timebase counter arrives as a pclk-synchronous input
// How it works
// - modes 0100-0111 select capture edge kinds
// - modes 1000-1011 select compare actions
// - mode field is control bits 3:0
// - qualifying event copies 16-bit timebase
// - each capture sets flag bit 2
// - flag stays set until software clears
// - new capture overwrites unread value
// - edge detector watches pin in any direction
// - mode change may raise spurious flag
// - prescaler held clear outside capture modes
// - any reset clears prescaler
// - prescale change keeps prescaler count
// - compare match applies pin action, sets flag
// - special trigger clears timebase, no overflow flag
module tcu_capture_unit (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timebase and pin
  input wire logic [15:0] timebase_count,
  input wire logic capture_pin,
  output tcu_pkg::tcu_out_t pin_ctrl,
  output logic irq
);
  tcu_pkg::tcu_ctrl_t ctrl_q, ctrl_d;
  logic [15:0] capture_q, capture_d;
  logic [15:0] compare_q, compare_d;
  logic flag_q, flag_d;
  logic irq_en_q, irq_en_d;
  logic [3:0] presc_q, presc_d;
  logic cap_pend_q, cap_pend_d;
  logic pin_q, pin_d;
  logic trig_q, trig_d;
  logic rise, fall;
  logic wr, rd_ok;
  logic event_hit, cmp_hit, is_capture, is_compare;
  logic [3:0] mode;

  tcu_edge_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async(capture_pin),
    .rise(rise),
    .fall(fall)
  );

  assign mode = ctrl_q.mode_select_field;
  assign is_capture = mode[3:2] == 2'b01;
  assign is_compare = mode[3:2] == 2'b10;
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign cmp_hit = is_compare & (compare_q == timebase_count);

  always_comb begin
    rd_ok = 1'b1;
    prdata = 32'h0000_0000;
    if (paddr == tcu_pkg::ADDR_MODE_CTRL) begin
      prdata = {26'h0, ctrl_q};
    end else if (paddr == tcu_pkg::ADDR_CAPTURE) begin
      prdata = {16'h0, capture_q};
    end else if (paddr == tcu_pkg::ADDR_COMPARE) begin
      prdata = {16'h0, compare_q};
    end else if (paddr == tcu_pkg::ADDR_FLAGS) begin
      prdata = {29'h0, flag_q, 2'b00};
    end else if (paddr == tcu_pkg::ADDR_ENABLES) begin
      prdata = {29'h0, irq_en_q, 2'b00};
    end else if (paddr == tcu_pkg::ADDR_TIMEBASE) begin
      prdata = {16'h0, timebase_count};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // event qualification and prescaler
  always_comb begin
    event_hit = 1'b0;
    presc_d = presc_q;
    if (!is_capture) begin
      presc_d = tcu_pkg::PRESCALE_RESET;
    end else begin
      case (tcu_pkg::tcu_mode_t'(mode))
        tcu_pkg::TCU_CAP_FALL: event_hit = fall;
        tcu_pkg::TCU_CAP_RISE: event_hit = rise;
        tcu_pkg::TCU_CAP_RISE4: begin
          if (rise) begin
            presc_d = (presc_q >= tcu_pkg::WRAP_BY4) ? 4'h0 : presc_q + 4'h1;
            event_hit = presc_q >= tcu_pkg::WRAP_BY4;
          end
        end
        default: begin
          if (rise) begin
            presc_d = presc_q + 4'h1;
            event_hit = presc_q == tcu_pkg::WRAP_BY16;
          end
        end
      endcase
    end
  end

  // registers, capture and flag
  always_comb begin
    ctrl_d = ctrl_q;
    compare_d = compare_q;
    irq_en_d = irq_en_q;
    capture_d = capture_q;
    flag_d = flag_q;
    pin_d = pin_q;
    trig_d = 1'b0;
    cap_pend_d = event_hit;
    if (wr && paddr == tcu_pkg::ADDR_MODE_CTRL) begin
      ctrl_d = tcu_pkg::tcu_ctrl_t'(pwdata[5:0] & tcu_pkg::MODE_CTRL_MASK);
    end else if (wr && paddr == tcu_pkg::ADDR_COMPARE) begin
      compare_d = pwdata[15:0];
    end else if (wr && paddr == tcu_pkg::ADDR_ENABLES) begin
      irq_en_d = pwdata[tcu_pkg::FLAG_BIT];
    end else if (wr && paddr == tcu_pkg::ADDR_FLAGS) begin
      flag_d = pwdata[tcu_pkg::FLAG_BIT];
    end
    if (cap_pend_q && is_capture) begin
      capture_d = timebase_count;
      flag_d = 1'b1;
    end
    if (cmp_hit) begin
      flag_d = 1'b1;
      if (mode == tcu_pkg::TCU_CMP_SET) pin_d = 1'b1;
      if (mode == tcu_pkg::TCU_CMP_CLR) pin_d = 1'b0;
      trig_d = mode == tcu_pkg::TCU_CMP_SPECIAL;
    end
    if (mode == tcu_pkg::TCU_OFF) begin
      pin_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= tcu_pkg::tcu_ctrl_t'(tcu_pkg::MODE_CTRL_RESET[5:0]);
      capture_q <= tcu_pkg::VALUE_RESET;
      compare_q <= tcu_pkg::VALUE_RESET;
      flag_q <= 1'b0;
      irq_en_q <= 1'b0;
      presc_q <= tcu_pkg::PRESCALE_RESET;
      cap_pend_q <= 1'b0;
      pin_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      capture_q <= capture_d;
      compare_q <= compare_d;
      flag_q <= flag_d;
      irq_en_q <= irq_en_d;
      presc_q <= presc_d;
      cap_pend_q <= cap_pend_d;
      pin_q <= pin_d;
      trig_q <= trig_d;
    end
  end

  assign pin_ctrl.timebase_clear = trig_q;
  assign pin_ctrl.compare_pin_out = pin_q;
  assign pin_ctrl.compare_pin_oe = is_compare & (mode != tcu_pkg::TCU_CMP_SWI)
    & (mode != tcu_pkg::TCU_CMP_SPECIAL);
  assign irq = flag_q & irq_en_q;

  // capture path
  a_capture_takes_time: assert property (@(posedge pclk) disable iff (!presetn)
    cap_pend_q && is_capture |=> capture_q == $past(timebase_count) && flag_q)
    else $error("capture did not store timebase");
  a_flag_holds_set: assert property (@(posedge pclk) disable iff (!presetn)
    flag_q && !(wr && paddr == tcu_pkg::ADDR_FLAGS) |=> flag_q)
    else $error("flag cleared by hardware");
  a_presc_held_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !is_capture |=> presc_q == 4'h0 || is_capture)
    else $error("prescaler not cleared");
  a_rise_capture_delay: assert property (@(posedge pclk) disable iff (!presetn)
    rise && mode == tcu_pkg::TCU_CAP_RISE ##1 is_capture |=> flag_q)
    else $error("rise did not capture");
  a_fall_capture_delay: assert property (@(posedge pclk) disable iff (!presetn)
    fall && mode == tcu_pkg::TCU_CAP_FALL ##1 is_capture |=> flag_q)
    else $error("fall did not capture");
  a_by4_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcu_pkg::TCU_CAP_RISE4 && rise |=> presc_q <= tcu_pkg::WRAP_BY4)
    else $error("prescaler beyond 4 range");
  a_capture_only_event: assert property (@(posedge pclk) disable iff (!presetn)
    !(cap_pend_q && is_capture) |=> $stable(capture_q))
    else $error("capture changed without event");
  a_pend_from_event: assert property (@(posedge pclk) disable iff (!presetn)
    cap_pend_q |-> $past(event_hit))
    else $error("pending capture without event");
  a_no_pend_outside: assert property (@(posedge pclk) disable iff (!presetn)
    !is_capture |=> !cap_pend_q)
    else $error("capture pending outside capture mode");
  a_fall_ignores_rise: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcu_pkg::TCU_CAP_FALL && rise |=> !cap_pend_q)
    else $error("rise captured in fall mode");
  a_rise_ignores_fall: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcu_pkg::TCU_CAP_RISE && fall |=> !cap_pend_q)
    else $error("fall captured in rise mode");
  a_edges_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    !(rise && fall))
    else $error("rise and fall together");

  // prescaler
  a_presc_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
    is_capture && !rise |=> $stable(presc_q))
    else $error("prescaler moved without rise");
  a_presc_edge_modes: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcu_pkg::TCU_CAP_FALL || mode == tcu_pkg::TCU_CAP_RISE |=> $stable(presc_q))
    else $error("prescaler moved in edge mode");
  a_by16_step: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcu_pkg::TCU_CAP_RISE16 && rise |=> presc_q == $past(presc_q) + 4'h1)
    else $error("by16 count step wrong");
  a_by16_event: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcu_pkg::TCU_CAP_RISE16 && rise && presc_q == tcu_pkg::WRAP_BY16 |=> cap_pend_q)
    else $error("by16 wrap did not capture");
  a_by16_no_event: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcu_pkg::TCU_CAP_RISE16 && rise && presc_q != tcu_pkg::WRAP_BY16 |=> !cap_pend_q)
    else $error("by16 captured early");
  a_by4_event: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcu_pkg::TCU_CAP_RISE4 && rise && presc_q >= tcu_pkg::WRAP_BY4
    |=> cap_pend_q && presc_q == 4'h0)
    else $error("by4 wrap did not capture");
  a_by4_step: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcu_pkg::TCU_CAP_RISE4 && rise && presc_q < tcu_pkg::WRAP_BY4
    |=> !cap_pend_q && presc_q == $past(presc_q) + 4'h1)
    else $error("by4 count step wrong");

  // flag and interrupt
  a_flag_set_capture: assert property (@(posedge pclk) disable iff (!presetn)
    cap_pend_q && is_capture |=> flag_q)
    else $error("capture did not set flag");
  a_flag_sw_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == tcu_pkg::ADDR_FLAGS && !pwdata[2] && !(cap_pend_q && is_capture)
    && !cmp_hit |=> !flag_q)
    else $error("software clear of flag lost");
  a_flag_sw_set: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == tcu_pkg::ADDR_FLAGS && pwdata[2] |=> flag_q)
    else $error("software set of flag lost");
  a_flag_rise_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flag_q) |-> $past((cap_pend_q && is_capture) || cmp_hit
    || (wr && paddr == tcu_pkg::ADDR_FLAGS)))
    else $error("flag set without cause");
  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (flag_q && irq_en_q))
    else $error("irq not flag and enable");
  a_irq_low_no_en: assert property (@(posedge pclk) disable iff (!presetn)
    !irq_en_q |-> !irq)
    else $error("irq while disabled");

  // compare path
  a_compare_sets_pin: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_hit && mode == tcu_pkg::TCU_CMP_SET |=> pin_q && flag_q)
    else $error("compare set missing");
  a_special_trigger: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_hit && mode == tcu_pkg::TCU_CMP_SPECIAL |=> trig_q ##1 !trig_q || $past(cmp_hit))
    else $error("special trigger wrong");
  a_clear_mode_code: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_hit && mode == tcu_pkg::TCU_CMP_CLR |=> !pin_q)
    else $error("compare clear missing");
  a_clear_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_hit && mode == tcu_pkg::TCU_CMP_CLR |=> flag_q)
    else $error("compare clear left flag low");
  a_swi_flag_only: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_hit && mode == tcu_pkg::TCU_CMP_SWI |=> flag_q && $stable(pin_q))
    else $error("software interrupt mode wrong");
  a_special_keeps_pin: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_hit && mode == tcu_pkg::TCU_CMP_SPECIAL |=> flag_q && $stable(pin_q))
    else $error("special trigger touched pin");
  a_trig_only_special: assert property (@(posedge pclk) disable iff (!presetn)
    trig_q |-> $past(cmp_hit && mode == tcu_pkg::TCU_CMP_SPECIAL))
    else $error("trigger outside special match");
  a_no_hit_capture: assert property (@(posedge pclk) disable iff (!presetn)
    is_capture |-> !cmp_hit)
    else $error("compare match in capture mode");
  a_pin_oe_modes: assert property (@(posedge pclk) disable iff (!presetn)
    pin_ctrl.compare_pin_oe == (mode == tcu_pkg::TCU_CMP_SET || mode == tcu_pkg::TCU_CMP_CLR))
    else $error("pin enable in wrong mode");
  a_off_clears_pin: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcu_pkg::TCU_OFF |=> !pin_q)
    else $error("pin latch not cleared when off");
  a_pin_stable_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !cmp_hit && mode != tcu_pkg::TCU_OFF |=> $stable(pin_q))
    else $error("pin latch moved without match");

  // register bus
  a_pready_high: assert property (@(posedge pclk) disable iff (!presetn)
    pready)
    else $error("pready low");
  a_pslverr_low: assert property (@(posedge pclk) disable iff (!presetn)
    !pslverr)
    else $error("pslverr high");
  a_rd_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_ok |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rd_capture_word: assert property (@(posedge pclk) disable iff (!presetn)
    paddr == tcu_pkg::ADDR_CAPTURE |-> prdata == {16'h0000, capture_q})
    else $error("capture read wrong");
  a_rd_flag_word: assert property (@(posedge pclk) disable iff (!presetn)
    paddr == tcu_pkg::ADDR_FLAGS |-> prdata == {29'h0000_0000, flag_q, 2'b00})
    else $error("flag read wrong");
  a_rd_timebase_word: assert property (@(posedge pclk) disable iff (!presetn)
    paddr == tcu_pkg::ADDR_TIMEBASE |-> prdata == {16'h0000, timebase_count})
    else $error("timebase read wrong");
  a_ctrl_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == tcu_pkg::ADDR_MODE_CTRL
    |=> {ctrl_q.duty_low_bits, ctrl_q.mode_select_field} == $past(pwdata[5:0]))
    else $error("control write lost");
  a_ctrl_stable: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && paddr == tcu_pkg::ADDR_MODE_CTRL) |=> $stable(ctrl_q))
    else $error("control changed without write");
  a_compare_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == tcu_pkg::ADDR_COMPARE |=> compare_q == $past(pwdata[15:0]))
    else $error("compare write lost");
  a_compare_stable: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && paddr == tcu_pkg::ADDR_COMPARE) |=> $stable(compare_q))
    else $error("compare changed without write");
  a_irq_en_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == tcu_pkg::ADDR_ENABLES |=> irq_en_q == $past(pwdata[2]))
    else $error("enable write lost");
  a_irq_en_stable: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && paddr == tcu_pkg::ADDR_ENABLES) |=> $stable(irq_en_q))
    else $error("enable changed without write");
endmodule

// File: hdl/tcu_pkg.sv
// tcu_pkg: register map, field layout, modes and reset values of the capture unit
// assumes a 32-bit apb slave, byte addresses, one word per register
package tcu_pkg;
  localparam logic [11:0] ADDR_MODE_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CAPTURE = 12'h004;
  localparam logic [11:0] ADDR_COMPARE = 12'h008;
  localparam logic [11:0] ADDR_FLAGS = 12'h00C;
  localparam logic [11:0] ADDR_ENABLES = 12'h010;
  localparam logic [11:0] ADDR_TIMEBASE = 12'h014;
  localparam int FLAG_BIT = 2;
  localparam int DIR_BIT = 2;
  localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
  localparam logic [5:0] MODE_CTRL_MASK = 6'h3F;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [3:0] PRESCALE_RESET = 4'h0;
  localparam logic [3:0] WRAP_BY4 = 4'h3;
  localparam logic [3:0] WRAP_BY16 = 4'hF;

  typedef enum logic [3:0] {
    TCU_OFF = 4'h0,
    TCU_CAP_FALL = 4'h4,
    TCU_CAP_RISE = 4'h5,
    TCU_CAP_RISE4 = 4'h6,
    TCU_CAP_RISE16 = 4'h7,
    TCU_CMP_SET = 4'h8,
    TCU_CMP_CLR = 4'h9,
    TCU_CMP_SWI = 4'hA,
    TCU_CMP_SPECIAL = 4'hB
  } tcu_mode_t;

  typedef struct packed {
    logic [1:0] duty_low_bits;
    logic [3:0] mode_select_field;
  } tcu_ctrl_t;

  typedef struct packed {
    logic timebase_clear;
    logic compare_pin_out;
    logic compare_pin_oe;
  } tcu_out_t;
endpackage

// File: hdl/tcu_edge_sync.sv
// tcu_edge_sync: two-stage synchroniser and edge detector for the capture pin
// assumes the pin is asynchronous to pclk
module tcu_edge_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and edges
  input wire logic pin_async,
  output logic rise,
  output logic fall
);
  logic meta_q, sync_q, last_q;
  logic meta_d, sync_d, last_d;

  always_comb begin
    meta_d = pin_async;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule

// File: verification/tcu_pin_model.sv
// tcu_pin_model: external event source on the capture pin
// assumes the bench calls edge_to just after a rising pclk edge
module tcu_pin_model (
  // clock and pin
  input wire logic pclk,
  output logic pin = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // drive a level, hold it 5..8 clocks (prompt and slow)
  task automatic edge_to(input logic v);
    pin <= v;
    repeat (5 + $urandom_range(3)) @(posedge pclk);
  endtask
endmodule

// File: verification/tcu_capture_unit_bench.sv
// tcu_capture_unit_bench: apb-driven self-checking test of the capture unit
// assumes tcu_pkg, the design and tcu_pin_model are compiled first
module tcu_capture_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] MC = tcu_pkg::ADDR_MODE_CTRL;
  localparam logic [11:0] FL = tcu_pkg::ADDR_FLAGS;
  localparam logic [11:0] CP = tcu_pkg::ADDR_CAPTURE;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, pin;
  int clr_seen = 0;
  int clr_base = 0;
  logic [15:0] tb = 16'h0000;
  logic [15:0] a, b;
  tcu_pkg::tcu_out_t pin_ctrl;
  logic [31:0] expq[$];
  int failures = 0;
  int checks_done = 0;
  always #10 pclk = ~pclk;
  tcu_capture_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timebase_count(tb), .capture_pin(pin), .pin_ctrl(pin_ctrl), .irq(irq));
  tcu_pin_model PM (.pclk(pclk), .pin(pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      PM.edge_to(1'b1);
      PM.edge_to(1'b0);
    end
  endtask
  // optional mode write (0 keeps mode), clear flag, n rises, check flag
  task automatic pre(input logic [3:0] m, input int n, input logic [31:0] e);
    if (m != 4'h0) apb(1'b1, MC, {28'h0, m});
    apb(1'b1, FL, 32'h0);
    pulses(n);
    rd(FL, e);
  endtask
  // read completions are compared against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk(prdata, expq.pop_front());
    if (psel && penable) chk({30'h0, pready, pslverr}, 32'h2);
    if (pin_ctrl.timebase_clear === 1'b1) clr_seen++;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    end_sim();
  end
  initial begin
    void'($urandom(8248));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(MC, 32'h0);
    rd(12'hFFC, 32'h0);
    apb(1'b1, tcu_pkg::ADDR_ENABLES, 32'h4);
    for (int m = 4; m < 6; m++) begin
      apb(1'b1, MC, 32'(m));
      a = 16'($urandom);
      b = ~a;
      tb <= a;
      PM.edge_to(1'b1);
      tb <= b;
      PM.edge_to(1'b0);
      rd(CP, {16'h0, (m == 5) ? a : b});
      repeat (20) @(posedge pclk);
      rd(FL, 32'h4);
      chk(32'(irq), 32'h1);
      apb(1'b1, FL, 32'h0);
    end
    tb <= a;
    pulses(1);
    tb <= b;
    pulses(1);
    apb(1'b1, CP, 32'h0);
    rd(CP, {16'h0, b});
    $display("test edge capture done");
    apb(1'b1, MC, 32'h0);
    pre(4'h6, 3, 32'h0);
    pre(4'h0, 1, 32'h4);
    pre(4'h7, 15, 32'h0);
    pre(4'h0, 1, 32'h4);
    pre(4'h6, 2, 32'h0);
    pre(4'h7, 14, 32'h4);
    pre(4'h6, 2, 32'h0);
    apb(1'b1, MC, 32'h0);
    pre(4'h6, 3, 32'h0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    pre(4'h6, 3, 32'h0);
    pre(4'h0, 1, 32'h4);
    $display("test prescaler done");
    tb <= b;
    for (int m = 8; m < 12; m++) begin
      apb(1'b1, FL, 32'h0);
      clr_base = clr_seen;
      apb(1'b1, tcu_pkg::ADDR_COMPARE, {16'h0, a});
      apb(1'b1, MC, 32'(m));
      tb <= a;
      repeat (3) @(posedge pclk);
      tb <= b;
      rd(FL, 32'h4);
      rd(tcu_pkg::ADDR_COMPARE, {16'h0, a});
      rd(tcu_pkg::ADDR_TIMEBASE, {16'h0, b});
      chk({29'h0, clr_seen != clr_base, pin_ctrl.compare_pin_out, pin_ctrl.compare_pin_oe},
        {29'h0, m == 11, m == 8, m < 10});
    end
    $display("test compare done");
    repeat (2) @(posedge pclk);
    end_sim();
  end
endmodule
